// >>> pmc_top.sv
/*
 * power mode controller: sequences full-on, active, sleep, deep sleep
 * and hibernate, drives the regulator wake line and gates clocks.
 * assumes all inputs synchronous to clk_i and a separate power-on
 * reset for the state kept through hibernate.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_top #(
    parameter int NUM_GPIO = `PMC_NUM_GPIO,
    parameter int NUM_IRQ = `PMC_NUM_IRQ
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic por_nrst_i,
    input wire pmc_pkg::pmc_req_type mode_req_i,
    input wire logic pll_bypass_i,
    input wire logic pll_off_i,
    input wire logic [NUM_IRQ-1:0] wakeup_enable_mask_i,
    input wire logic [NUM_IRQ-1:0] irq_i,
    input wire logic [NUM_GPIO-1:0] gpio_level_i,
    input wire logic vr_wr_i,
    input wire logic [NUM_GPIO+1:0] vr_wdata_i,
    input wire logic power_good_in_i,
    output logic [NUM_GPIO+1:0] regulator_control_reg_o,
    output pmc_pkg::pmc_mode_type mode_o,
    output pmc_pkg::pmc_gate_type gate_o,
    output logic regulator_wake_out_o,
    output logic hw_reset_seq_o,
    output logic resume_o,
    output logic req_refused_o
);
    import pmc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // declarations
    pmc_mode_type mode_q; // current mode
    pmc_mode_type mode_d;
    pmc_gate_type gate_d; // gating for next mode
    logic [NUM_GPIO+1:0] regulator_control_reg; // kept register contents
    logic gpio_wake; // qualified gpio wake
    logic [2:0] pg_cnt_q; // power good settle count
    logic [2:0] pg_cnt_d;
    logic wake_q; // regulator wake line
    logic wake_d;
    logic hw_reset_q; // reset sequence pulse
    logic resume_q; // resume-from-pc pulse
    logic refused_q; // refused request pulse
    logic refused_d;
    localparam pmc_gate_type HIB_GATE = pmc_gate_type'(7'h01); // only the pins float

    ////////////////////////////////////////////////////////////////////
    // submodules
    // kept on the io supply, only por resets it, to 10'h001
    pmc_reg_keep #(.WIDTH(NUM_GPIO + 2)) u_vr (
        .clk_i(clk_i),
        .por_nrst_i(por_nrst_i),
        .wr_i(vr_wr_i),
        .wdata_i(vr_wdata_i),
        .rdata_o(regulator_control_reg)
    );

    // gpio wake must persist the minimum hold
    pmc_wake_filter #(.WIDTH(NUM_GPIO)) u_wf (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .level_i(gpio_level_i),
        .enable_i(regulator_control_reg[NUM_GPIO+1:2]),
        .wake_o(gpio_wake)
    );

    ////////////////////////////////////////////////////////////////////
    // decoding
    wire irq_wake = |(irq_i & wakeup_enable_mask_i);
    wire keep_bit = regulator_control_reg[`PMC_VR_KEEP_BIT];
    // the pin reset only wakes hibernate when enabled
    wire reset_wake_en = regulator_control_reg[`PMC_VR_RESET_WAKE_BIT];
    // bypass sampled on sleep wake selects the target
    wire pmc_mode_type sleep_exit = pll_bypass_i ? PMC_ACTIVE : PMC_FULL_ON;
    // pll-off set blocks full-on and sleep
    wire pll_off_block = pll_off_i &&
        (mode_req_i == PMC_REQ_FULL_ON || mode_req_i == PMC_REQ_SLEEP);
    // settled only while the supply is still good, a late dip holds off
    wire pg_ok = power_good_in_i && (pg_cnt_q == 3'(`PMC_PG_SETTLE_CYC));
    // hibernate wake: enabled gpio wake (pin reset handled in reset branch)
    wire hib_wake = gpio_wake;

    ////////////////////////////////////////////////////////////////////
    // next mode selection
    always_comb begin
        mode_d = mode_q;
        refused_d = 1'b0;
        case (mode_q)
            PMC_POWER_UP: begin
                // wait for regulator to settle
                if (pg_ok) begin
                    mode_d = PMC_FULL_ON;
                end
            end
            PMC_FULL_ON, PMC_ACTIVE: begin
                if (pll_off_block) begin
                    refused_d = 1'b1;
                end else begin
                    case (mode_req_i)
                        PMC_REQ_FULL_ON: mode_d = PMC_FULL_ON;
                        PMC_REQ_ACTIVE: mode_d = PMC_ACTIVE;
                        PMC_REQ_SLEEP: mode_d = PMC_SLEEP;
                        PMC_REQ_DEEP_SLEEP: mode_d = PMC_DEEP_SLEEP;
                        PMC_REQ_HIBERNATE: mode_d = PMC_HIBERNATE;
                        default: mode_d = mode_q;
                    endcase
                end
                // clearing the keep bit alone also hibernates
                if (!keep_bit) begin
                    mode_d = PMC_HIBERNATE;
                end
            end
            PMC_SLEEP: begin
                if (irq_wake) begin
                    mode_d = sleep_exit;
                end
            end
            PMC_DEEP_SLEEP: begin
                // only gpio wake; irq and requests ignored
                if (gpio_wake) begin
                    mode_d = PMC_ACTIVE;
                end
            end
            PMC_HIBERNATE: begin
                // wake restarts from power-up, never resumes
                if (hib_wake) begin
                    mode_d = PMC_POWER_UP;
                end
            end
            default: mode_d = PMC_POWER_UP;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // gating implied by the next mode
    always_comb begin
        gate_d = '0;
        case (mode_d)
            PMC_FULL_ON: begin
                gate_d.pll_enable = 1'b1;
                gate_d.core_clk_en = 1'b1;
                gate_d.sys_clk_en = 1'b1;
                gate_d.dma_l1_allow = 1'b1;
                gate_d.async_access_allow = 1'b1;
            end
            PMC_ACTIVE: begin
                gate_d.pll_enable = !pll_off_i;
                gate_d.pll_bypass = 1'b1;
                gate_d.core_clk_en = 1'b1;
                gate_d.sys_clk_en = 1'b1;
                gate_d.dma_l1_allow = 1'b1;
                gate_d.async_access_allow = 1'b1;
            end
            PMC_SLEEP: begin
                gate_d.pll_enable = 1'b1;
                gate_d.pll_bypass = pll_bypass_i;
                gate_d.sys_clk_en = 1'b1;
                gate_d.async_access_allow = 1'b1;
                gate_d.dma_l1_allow = 1'b0;
            end
            PMC_DEEP_SLEEP: begin
                // all clocks off, async accesses blocked
                gate_d.async_access_allow = 1'b0;
            end
            PMC_HIBERNATE: begin
                gate_d.pins_hiz = 1'b1;
            end
            default: begin
                // power-up: nothing runs until power good
                gate_d.pins_hiz = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // regulator wake: low only in hibernate
    assign wake_d = (mode_d != PMC_HIBERNATE);
    // power good settle counter, cleared while power is down
    assign pg_cnt_d = (!power_good_in_i || mode_q != PMC_POWER_UP) ? 3'h0 :
        (pg_ok ? pg_cnt_q : pg_cnt_q + 3'h1);

    ////////////////////////////////////////////////////////////////////
    // state and outputs
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            // reset from deep sleep lands in full-on after power good
            // a hibernate reset wake is gated by its enable
            if (mode_q == PMC_HIBERNATE && !reset_wake_en) begin
                // stays down: wake low, clocks off, pins still floating
                mode_q <= PMC_HIBERNATE;
                gate_o <= HIB_GATE;
                wake_q <= 1'b0;
                hw_reset_q <= 1'b0;
            end else begin
                mode_q <= PMC_POWER_UP;
                gate_o <= '0;
                wake_q <= 1'b1;
                hw_reset_q <= 1'b1;
            end
            resume_q <= 1'b0;
            refused_q <= 1'b0;
            pg_cnt_q <= 3'h0;
        end else begin
            mode_q <= mode_d;
            gate_o <= gate_d;
            wake_q <= wake_d;
            hw_reset_q <= (mode_q == PMC_HIBERNATE) && (mode_d == PMC_POWER_UP);
            resume_q <= (mode_q == PMC_DEEP_SLEEP) && (mode_d == PMC_ACTIVE);
            refused_q <= refused_d;
            pg_cnt_q <= pg_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output registers
    always_ff @(posedge clk_i) begin
        if (!por_nrst_i) begin
            regulator_control_reg_o <= '0;
        end else begin
            regulator_control_reg_o <= regulator_control_reg;
        end
    end
    assign mode_o = mode_q;
    assign regulator_wake_out_o = wake_q;
    assign hw_reset_seq_o = hw_reset_q;
    assign resume_o = resume_q;
    assign req_refused_o = refused_q;

    ////////////////////////////////////////////////////////////////////
    // assertions
    sleep_wake_mode_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_q == PMC_SLEEP && irq_wake |=> mode_q == $past(sleep_exit))
        else $error("sleep wake went to wrong mode");
    sleep_core_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_q == PMC_SLEEP |-> !gate_o.core_clk_en && gate_o.sys_clk_en && gate_o.pll_enable)
        else $error("sleep gating wrong");
    deep_ignore_irq_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_q == PMC_DEEP_SLEEP && !gpio_wake |=> mode_q == PMC_DEEP_SLEEP)
        else $error("deep sleep left without gpio wake");
    deep_gpio_exit_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_q == PMC_DEEP_SLEEP && gpio_wake |=> mode_q == PMC_ACTIVE && resume_q)
        else $error("gpio wake did not reach active");
    deep_gate_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_q == PMC_DEEP_SLEEP |-> !gate_o.core_clk_en && !gate_o.sys_clk_en
        && !gate_o.async_access_allow)
        else $error("deep sleep gating wrong");
    hib_wake_low_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_q == PMC_HIBERNATE |-> !regulator_wake_out_o)
        else $error("wake high in hibernate");
    hib_pins_hiz_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_q == PMC_HIBERNATE |-> gate_o.pins_hiz && !gate_o.core_clk_en && !gate_o.sys_clk_en)
        else $error("hibernate pins or clocks wrong");
    sleep_dma_block_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $past(mode_q) == PMC_SLEEP && mode_q == PMC_SLEEP |-> !gate_o.dma_l1_allow)
        else $error("dma allowed in sleep");
    active_bypass_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_q == PMC_ACTIVE |-> gate_o.pll_bypass && gate_o.core_clk_en)
        else $error("active without bypass");
    fullon_pll_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_q == PMC_FULL_ON |-> gate_o.pll_enable && !gate_o.pll_bypass)
        else $error("full-on pll wrong");
    pg_holdoff_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_q == PMC_POWER_UP && !power_good_in_i |=> mode_q == PMC_POWER_UP)
        else $error("started without power good");
    hib_restart_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_q == PMC_HIBERNATE && hib_wake |=> mode_q == PMC_POWER_UP ##0 hw_reset_q)
        else $error("hibernate wake did not restart");
    rst_hib_hold_a: assert property (@(posedge clk_i)
        !nrst_i && mode_q == PMC_HIBERNATE && !reset_wake_en
        |=> mode_q == PMC_HIBERNATE && !wake_q && gate_o.pins_hiz)
        else $error("disabled reset woke hibernate");
    rst_hib_wake_a: assert property (@(posedge clk_i)
        !nrst_i && mode_q == PMC_HIBERNATE && reset_wake_en
        |=> mode_q == PMC_POWER_UP && wake_q && hw_reset_q)
        else $error("enabled reset did not restart");
    pll_off_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_q == PMC_ACTIVE && pll_off_i && keep_bit
        && mode_req_i == PMC_REQ_FULL_ON |=> mode_q == PMC_ACTIVE && refused_q)
        else $error("full-on taken with pll off");
    cov_sleep_c: cover property (@(posedge clk_i) mode_q == PMC_SLEEP ##1 mode_q == PMC_FULL_ON);
    cov_deep_c: cover property (@(posedge clk_i) mode_q == PMC_DEEP_SLEEP ##1 mode_q == PMC_ACTIVE);
    cov_hib_c: cover property (@(posedge clk_i) mode_q == PMC_HIBERNATE ##1 mode_q == PMC_POWER_UP);
    cov_refuse_c: cover property (@(posedge clk_i) mode_q == PMC_ACTIVE && refused_q);

endmodule
`default_nettype wire

// >>> pmc_consts.svh
/*
 * timing counts and field positions for the power mode controller.
 * assumes a 50 MHz clk_i; included by bare name.
 */
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define PMC_CLK_PERIOD_NS 20
`define PMC_WAKE_HOLD_NS 10
// least time rounds up, never below one cycle
`define PMC_WAKE_HOLD_CYC ((`PMC_WAKE_HOLD_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_NUM_GPIO 8
`define PMC_NUM_IRQ 8
`define PMC_PG_SETTLE_CYC 4
// regulator control register fields
`define PMC_VR_KEEP_BIT 0
`define PMC_VR_RESET_WAKE_BIT 1
`define PMC_REGULATOR_CONTROL_REG_RESET 10'h001

`endif

// >>> pmc_pkg.sv
/*
 * types for the power mode controller.
 * assumes nothing beyond the constants header.
 */
package pmc_pkg;

    // operating mode, binary coded
    typedef enum logic [2:0] {
        PMC_FULL_ON = 3'h0,
        PMC_ACTIVE = 3'h1,
        PMC_SLEEP = 3'h2,
        PMC_DEEP_SLEEP = 3'h3,
        PMC_HIBERNATE = 3'h4,
        PMC_POWER_UP = 3'h5
    } pmc_mode_type;

    // software request codes
    typedef enum logic [2:0] {
        PMC_REQ_NONE = 3'h0,
        PMC_REQ_FULL_ON = 3'h1,
        PMC_REQ_ACTIVE = 3'h2,
        PMC_REQ_SLEEP = 3'h3,
        PMC_REQ_DEEP_SLEEP = 3'h4,
        PMC_REQ_HIBERNATE = 3'h5
    } pmc_req_type;

    // clock and access gating bundle
    typedef struct packed {
        logic pll_enable;
        logic pll_bypass;
        logic core_clk_en;
        logic sys_clk_en;
        logic dma_l1_allow;
        logic async_access_allow;
        logic pins_hiz;
    } pmc_gate_type;

endpackage

// >>> pmc_wake_filter.sv
/*
 * qualifies gpio wake levels that must persist a minimum time.
 * assumes gpio inputs synchronous to clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_wake_filter #(
    parameter int WIDTH = `PMC_NUM_GPIO,
    parameter int HOLD = `PMC_WAKE_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] level_i,
    input wire logic [WIDTH-1:0] enable_i,
    output logic wake_o
);

    ////////////////////////////////////////////////////////////////////
    logic [WIDTH-1:0] seen_q;
    logic [WIDTH-1:0] seen_d;

    // one qualifier per pin
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            logic [3:0] cnt_q;
            logic [3:0] cnt_d;
            // count consecutive cycles at the wake level
            assign cnt_d = (level_i[g] && enable_i[g]) ?
                ((cnt_q == 4'(HOLD)) ? cnt_q : cnt_q + 4'h1) : 4'h0;
            assign seen_d[g] = (cnt_d == 4'(HOLD));
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    cnt_q <= 4'h0;
                end else begin
                    cnt_q <= cnt_d;
                end
            end
        end
    endgenerate

    // registered wake pulse level
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            seen_q <= '0;
        end else begin
            seen_q <= seen_d;
        end
    end
    assign wake_o = |seen_q;

endmodule
`default_nettype wire

// >>> pmc_reg_keep.sv
/*
 * regulator control register, kept through hibernate.
 * assumes it sits on the io supply and sees only the power-on reset.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_reg_keep #(
    parameter int WIDTH = 10
) (
    input wire logic clk_i,
    input wire logic por_nrst_i,
    input wire logic wr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] rdata_o
);

    ////////////////////////////////////////////////////////////////////
    // only a power-on reset loads it, with 10'h001; hibernate does not
    always_ff @(posedge clk_i) begin
        if (!por_nrst_i) begin
            rdata_o <= WIDTH'(`PMC_REGULATOR_CONTROL_REG_RESET);
        end else if (wr_i) begin
            rdata_o <= wdata_i;
        end
    end

endmodule
`default_nettype wire

// >>> pmc_regulator_model.sv
/*
 * far side of the controller: regulator that follows the wake line
 * and a gpio wake source that stretches each request.
 * assumes the bench pulses gpio_req_i for one cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module pmc_regulator_model #(
    parameter int RAMP = 6,
    parameter int HOLD = 2
) (
    input wire logic clk_i,
    input wire logic wake_i,
    input wire logic [7:0] gpio_req_i,
    output logic power_good_o,
    output logic [7:0] gpio_level_o
);
    logic [3:0] ramp_q = 4'h0; // supply ramp progress
    logic [3:0] hold_q = 4'h0; // gpio hold left
    logic [7:0] held_q = 8'h00; // stretched wake level

    logic pg_q = 1'h0; // supply good flag
    assign power_good_o = pg_q;
    assign gpio_level_o = held_q;

    ////////////////////////////////////////////////////////////////////
    // supply drops at once on shutdown, good only after a full ramp
    always @(posedge clk_i) begin
        if (wake_i !== 1'h1) begin
            ramp_q <= 4'h0;
            pg_q <= 1'h0;
        end else if (ramp_q != RAMP[3:0]) begin
            ramp_q <= ramp_q + 4'h1;
        end else begin
            pg_q <= 1'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wake level lingers HOLD+1 cycles, well past 10 ns
    always @(posedge clk_i) begin
        if (gpio_req_i != 8'h00) begin
            held_q <= gpio_req_i;
            hold_q <= HOLD[3:0];
        end else if (hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
        end else begin
            held_q <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// >>> power_mode_controller_test.sv
/*
 * self-checking bench for the power mode controller.
 * assumes the regulator model on the far side; inputs move at negedge.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module power_mode_controller_test;
    import pmc_pkg::*;
    logic clk_i = 1'h0;
    logic nrst_i = 1'h0;
    logic por_nrst_i = 1'h0;
    pmc_req_type mode_req_i = PMC_REQ_NONE;
    logic pll_bypass_i = 1'h0;
    logic pll_off_i = 1'h0;
    logic [7:0] mask_i = 8'h00; // wakeup_enable_mask
    logic [7:0] irq_i = 8'h00;
    logic [7:0] gpio_req = 8'h00;
    logic [7:0] gpio_level;
    logic vr_wr_i = 1'h0;
    logic [9:0] vr_wdata_i = 10'h000;
    logic power_good;
    logic [9:0] vr_q;
    pmc_mode_type mode_o;
    pmc_gate_type gate_o;
    logic wake_o, hw_o, resume_o, refused_o;
    logic refused_seen = 1'h0, resume_seen = 1'h0, hw_seen = 1'h0; // sticky pulse catchers
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    pmc_req_type bad_req[2] = '{PMC_REQ_FULL_ON, PMC_REQ_SLEEP};

    pmc_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .por_nrst_i(por_nrst_i),
        .mode_req_i(mode_req_i), .pll_bypass_i(pll_bypass_i), .pll_off_i(pll_off_i),
        .wakeup_enable_mask_i(mask_i), .irq_i(irq_i), .gpio_level_i(gpio_level),
        .vr_wr_i(vr_wr_i), .vr_wdata_i(vr_wdata_i), .power_good_in_i(power_good),
        .regulator_control_reg_o(vr_q), .mode_o(mode_o), .gate_o(gate_o),
        .regulator_wake_out_o(wake_o), .hw_reset_seq_o(hw_o), .resume_o(resume_o),
        .req_refused_o(refused_o));

    pmc_regulator_model #(.RAMP(6), .HOLD(2)) partner (.clk_i(clk_i), .wake_i(wake_o),
        .gpio_req_i(gpio_req), .power_good_o(power_good), .gpio_level_o(gpio_level));

    ////////////////////////////////////////////////////////////////////
    // clock, pulse catchers and hang guard
    initial forever #10 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (refused_o === 1'h1) refused_seen <= 1'h1;
        if (resume_o === 1'h1) resume_seen <= 1'h1;
        if (hw_o === 1'h1) hw_seen <= 1'h1;
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // access tasks
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic request(input pmc_req_type r);
        mode_req_i = r;
        tick(1);
        mode_req_i = PMC_REQ_NONE;
    endtask

    task automatic vr_write(input logic [9:0] d);
        vr_wdata_i = d;
        vr_wr_i = 1'h1;
        tick(1);
        vr_wr_i = 1'h0;
    endtask

    // bounded wait, then the mode must match
    task automatic wait_mode(input pmc_mode_type m);
        for (int k = 0; k < 40 && mode_o !== m; k++) tick(1);
        `CHK(mode_o, m)
    endtask

    // start is held off until the supply is good
    task automatic wait_pg();
        for (int k = 0; k < 40 && power_good !== 1'h1; k++) tick(1);
        `CHK(mode_o, PMC_POWER_UP)
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        tick(2);
        nrst_i = 1'h1;
        por_nrst_i = 1'h1;
        tick(2);
        `CHK(vr_q, 10'h001)
        wait_pg();
        wait_mode(PMC_FULL_ON);
        `CHK(gate_o, 7'h5E)
        request(PMC_REQ_ACTIVE);
        wait_mode(PMC_ACTIVE);
        `CHK(gate_o, 7'h7E)
        // pll input off: full-on and sleep must both bounce
        pll_off_i = 1'h1;
        foreach (bad_req[i]) begin
            refused_seen = 1'h0;
            request(bad_req[i]);
            tick(3);
            `CHK(refused_seen, 1'h1)
            `CHK(mode_o, PMC_ACTIVE)
        end
        pll_off_i = 1'h0;
        // sleep twice: bypass clear wakes to full-on, set to active
        for (int i = 0; i < 2; i++) begin
            pll_bypass_i = i[0];
            request(PMC_REQ_SLEEP);
            wait_mode(PMC_SLEEP);
            `CHK({gate_o.pll_enable, gate_o.core_clk_en, gate_o.sys_clk_en, gate_o.dma_l1_allow}, 4'hA)
            irq_i = 8'h01;
            mask_i = 8'h02;
            tick(4);
            `CHK(mode_o, PMC_SLEEP)
            mask_i = 8'h03;
            wait_mode(i == 1 ? PMC_ACTIVE : PMC_FULL_ON);
            irq_i = 8'h00;
            mask_i = 8'h00;
        end
        pll_bypass_i = 1'h0;
        // deep sleep: only an enabled gpio gets out, back to active
        vr_write(10'h005);
        request(PMC_REQ_DEEP_SLEEP);
        wait_mode(PMC_DEEP_SLEEP);
        `CHK({gate_o.pll_enable, gate_o.core_clk_en, gate_o.sys_clk_en, gate_o.async_access_allow}, 4'h0)
        irq_i = 8'hFF;
        mask_i = 8'hFF;
        request(PMC_REQ_FULL_ON);
        gpio_req = 8'h02;
        tick(1);
        gpio_req = 8'h00;
        tick(4);
        `CHK(mode_o, PMC_DEEP_SLEEP)
        irq_i = 8'h00;
        mask_i = 8'h00;
        resume_seen = 1'h0;
        gpio_req = 8'h01;
        tick(1);
        gpio_req = 8'h00;
        wait_mode(PMC_ACTIVE);
        tick(2);
        `CHK(resume_seen, 1'h1)
        // pin reset in deep sleep lands in full-on
        request(PMC_REQ_DEEP_SLEEP);
        wait_mode(PMC_DEEP_SLEEP);
        nrst_i = 1'h0;
        tick(2);
        nrst_i = 1'h1;
        wait_mode(PMC_FULL_ON);
        // hibernate by clearing the keep bit, gpio0 wake enabled
        vr_write(10'h004);
        wait_mode(PMC_HIBERNATE);
        tick(3);
        `CHK({gate_o.core_clk_en, gate_o.sys_clk_en, gate_o.pins_hiz, wake_o}, 4'h2)
        `CHK(vr_q, 10'h004)
        gpio_req = 8'h02;
        tick(1);
        gpio_req = 8'h00;
        tick(4);
        `CHK(wake_o, 1'h0)
        hw_seen = 1'h0;
        resume_seen = 1'h0;
        gpio_req = 8'h01;
        tick(1);
        gpio_req = 8'h00;
        for (int k = 0; k < 20 && wake_o !== 1'h1; k++) tick(1);
        `CHK(wake_o, 1'h1)
        vr_write(10'h005);
        wait_pg();
        `CHK(hw_seen, 1'h1)
        wait_mode(PMC_FULL_ON);
        `CHK(resume_seen, 1'h0)
        // pin reset in hibernate: ignored until its enable bit is set
        vr_write(10'h004);
        wait_mode(PMC_HIBERNATE);
        hw_seen = 1'h0;
        nrst_i = 1'h0;
        tick(2);
        nrst_i = 1'h1;
        tick(1);
        `CHK(mode_o, PMC_HIBERNATE)
        `CHK(wake_o, 1'h0)
        `CHK(hw_seen, 1'h0)
        vr_write(10'h006);
        nrst_i = 1'h0;
        tick(2);
        nrst_i = 1'h1;
        wait_pg();
        `CHK(hw_seen, 1'h1)
        `CHK(vr_q, 10'h006)
        vr_write(10'h005);
        wait_mode(PMC_FULL_ON);
        give_verdict();
    end
endmodule
`default_nettype wire
